// file: verilog/fspc_top.sv
// sector program flash controller: array, sector guard, erase engine, register port
// assumes a 10 MHz system clock and a tool-driven link clock unrelated in phase
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module fspc_top
#(
  parameter int ARRAY_BYTES = 32768
)
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic tool_socket_mode_i,
  input wire logic prog_voltage_select_i,
  input wire logic incircuit_link_clock_i,
  input wire logic incircuit_link_data_i,
  output logic incircuit_link_data_o,
  output logic incircuit_link_data_oe_o,
  output logic link_pins_reserved_o,
  output logic busy_o
);
  import fspc_pkg::*;

  localparam int AW = $clog2(ARRAY_BYTES);
  localparam logic [15:0] ARRAY_BASE = 16'(ADDR_SPACE - ARRAY_BYTES);
  // sector count follows array size
  localparam int NUM_SECTORS = (ARRAY_BYTES <= SECTOR_BYTES) ? 1 :
                               (ARRAY_BYTES <= 2 * SECTOR_BYTES) ? 2 : 3;

  if (ARRAY_BYTES < SECTOR_BYTES || ARRAY_BYTES > ADDR_SPACE ||
      ARRAY_BYTES % SECTOR_BYTES != 0)
  begin : g_bad_size
    $error("ARRAY_BYTES must be a multiple of 4096 between 4096 and 65536");
  end

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [2:0][2:0] pin_sync_q;
  logic [2:0] pin_q;
  logic frame_seen_q;
  logic frame_tgl;
  fspc_frame_t frame;
  logic link_pend_q;
  logic board_mode_q;
  logic app_mode_q;
  logic refused_q;
  logic [15:0] addr_q;
  logic [7:0] data_q;
  logic [7:0] option_q;
  logic opt_pend_q;
  logic [7:0] opt_val_q;
  fspc_eng_t state_q;
  logic [15:0] erase_ptr_q;
  logic [15:0] erase_end_q;
  logic [7:0] reply_q;
  logic reply_tgl_q;
  logic [7:0] mem [ARRAY_BYTES];
  fspc_req_t cpu_req;
  fspc_req_t link_req;
  fspc_req_t req;
  logic take_cpu;
  logic take_link;
  logic privileged;
  logic permit;
  logic refuse;
  logic start_erase;
  logic [15:0] erase_lo;
  logic [15:0] erase_hi;
  logic mem_we;
  logic [AW-1:0] mem_widx;
  logic [7:0] mem_wdata;
  logic protect;
  logic unprotect;

  function automatic logic [1:0] sector_of(input logic [15:0] a);
    if (a >= SECTOR0_BASE)
      return 2'h0;
    else if (a >= SECTOR1_BASE)
      return 2'h1;
    else
      return 2'h2;
  endfunction

  function automatic logic in_array(input logic [15:0] a);
    return (a >= ARRAY_BASE);
  endfunction

  function automatic logic [AW-1:0] index_of(input logic [15:0] a);
    logic [15:0] off;
    off = a - ARRAY_BASE;
    return off[AW-1:0];
  endfunction

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  fspc_link u_link
  (
    .link_clk_i(incircuit_link_clock_i),
    .reset_n_i(rst_n),
    .select_i(prog_voltage_select_i),
    .data_i(incircuit_link_data_i),
    .reply_i(reply_q),
    .reply_tgl_i(reply_tgl_q),
    .frame_o(frame),
    .frame_tgl_o(frame_tgl),
    .data_o(incircuit_link_data_o),
    .data_oe_o(incircuit_link_data_oe_o)
  );

  // pins and the frame toggle: three stages, a change counts once stages two and three agree
  for (genvar i = 0; i < 3; i++)
  begin : g_sync
    logic src;
    if (i == 0)
    begin : g_tgl
      assign src = frame_tgl;
    end
    else if (i == 1)
    begin : g_sel
      assign src = prog_voltage_select_i;
    end
    else
    begin : g_tool
      assign src = tool_socket_mode_i;
    end
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
      if (!rst_n)
      begin
        pin_sync_q[i] <= 3'b000;
        pin_q[i] <= 1'b0;
      end
      else
      begin
        pin_sync_q[i] <= {pin_sync_q[i][1:0], src};
        if (pin_sync_q[i][1] == pin_sync_q[i][2])
          pin_q[i] <= pin_sync_q[i][2];
      end
    end
  end

  assign protect = option_q[OPT_READOUT_PROTECT];
  assign privileged = pin_q[2] | board_mode_q;

  // request decode: cpu start bits outrank a pending link frame
  always_comb
  begin
    cpu_req = '{op: OP_NONE, addr: addr_q, data: data_q};
    if (reg_wr_i && reg_addr_i == REG_CTRL_STATUS)
    begin
      if (reg_wdata_i[CTRL_PROG])
        cpu_req.op = OP_PROG;
      else if (reg_wdata_i[CTRL_SECT_ERASE])
        cpu_req.op = OP_SECT_ERASE;
      else if (reg_wdata_i[CTRL_MASS_ERASE])
        cpu_req.op = OP_MASS_ERASE;
    end
    link_req = '{op: OP_NONE, addr: frame.addr, data: frame.data};
    case (frame.cmd)
      CMD_ENTER: link_req.op = OP_ENTER;
      CMD_PROG: link_req.op = OP_PROG;
      CMD_SECT_ERASE: link_req.op = OP_SECT_ERASE;
      CMD_MASS_ERASE: link_req.op = OP_MASS_ERASE;
      CMD_READ: link_req.op = OP_READ;
      CMD_OPTION: link_req.op = OP_OPTION;
      default: link_req.op = OP_NONE;
    endcase
  end

  always_comb
  begin
    take_cpu = (cpu_req.op != OP_NONE);
    take_link = !take_cpu && link_pend_q && state_q == ENG_IDLE;
    req = take_cpu ? cpu_req : link_req;
    permit = 1'b0;
    if (take_link)
      permit = privileged || req.op == OP_ENTER || req.op == OP_NONE;
    else if (take_cpu)
    begin
      if (privileged)
        permit = 1'b1;
      else if (app_mode_q)
        permit = req.op != OP_MASS_ERASE && sector_of(req.addr) != 2'h0;
    end
    if ((req.op == OP_PROG || req.op == OP_SECT_ERASE) &&
        (!in_array(req.addr) || 32'(sector_of(req.addr)) >= NUM_SECTORS))
      permit = 1'b0;
    if (take_link && req.op == OP_ENTER && !pin_q[1])
      permit = 1'b0;
    // a busy engine refuses cpu starts rather than queue them
    refuse = (take_cpu && (state_q != ENG_IDLE || !permit)) || (take_link && !permit);
    unprotect = req.op == OP_OPTION && protect && !req.data[OPT_READOUT_PROTECT];
    start_erase = !refuse && (take_cpu || take_link) &&
                  (req.op == OP_SECT_ERASE || req.op == OP_MASS_ERASE || unprotect);
    erase_hi = TOP_ADDR;
    erase_lo = ARRAY_BASE;
    if (req.op == OP_SECT_ERASE)
    begin
      case (sector_of(req.addr))
        2'h0: erase_lo = SECTOR0_BASE;
        2'h1:
        begin
          erase_lo = SECTOR1_BASE;
          erase_hi = SECTOR0_BASE - 16'h0001;
        end
        default: erase_hi = SECTOR1_BASE - 16'h0001;
      endcase
    end
  end

  // single write port: erase walks the range one byte a cycle, program clears bits only
  always_comb
  begin
    mem_we = 1'b0;
    mem_widx = index_of(erase_ptr_q);
    mem_wdata = ERASED_BYTE;
    if (state_q == ENG_ERASE)
      mem_we = 1'b1;
    else if (!refuse && (take_cpu || take_link) && req.op == OP_PROG)
    begin
      mem_we = 1'b1;
      mem_widx = index_of(req.addr);
      mem_wdata = mem[index_of(req.addr)] & req.data;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (mem_we)
      mem[mem_widx] <= mem_wdata;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ENG_IDLE;
      erase_ptr_q <= 16'h0000;
      erase_end_q <= 16'h0000;
    end
    else
    begin
      case (state_q)
        ENG_IDLE:
        begin
          if (start_erase)
          begin
            state_q <= ENG_ERASE;
            erase_ptr_q <= erase_lo;
            erase_end_q <= erase_hi;
          end
        end
        ENG_ERASE:
        begin
          if (erase_ptr_q == erase_end_q)
            state_q <= ENG_IDLE;
          else
            erase_ptr_q <= erase_ptr_q + 16'h0001;
        end
        default: state_q <= ENG_IDLE;
      endcase
    end
  end

  // option byte: dropping protection is only written after the full erase ends
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      option_q <= OPTION_RESET;
      opt_pend_q <= 1'b0;
      opt_val_q <= OPTION_RESET;
    end
    else if (take_link && !refuse && req.op == OP_OPTION)
    begin
      if (unprotect)
      begin
        opt_pend_q <= 1'b1;
        opt_val_q <= req.data;
      end
      else
        option_q <= req.data;
    end
    else if (opt_pend_q && state_q == ENG_ERASE && erase_ptr_q == erase_end_q)
    begin
      option_q <= opt_val_q;
      opt_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_seen_q <= 1'b0;
      link_pend_q <= 1'b0;
    end
    else if (pin_q[0] != frame_seen_q)
    begin
      frame_seen_q <= pin_q[0];
      link_pend_q <= 1'b1;
    end
    else if (take_link)
      link_pend_q <= 1'b0;
  end

  // in-circuit mode lasts while the select pin stays high
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      board_mode_q <= 1'b0;
    else if (!pin_q[1])
      board_mode_q <= 1'b0;
    else if (take_link && permit && req.op == OP_ENTER)
      board_mode_q <= 1'b1;
  end

  // reads from outside return 00h while protected
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reply_q <= 8'h00;
      reply_tgl_q <= 1'b0;
    end
    else if (take_link && permit && req.op == OP_READ)
    begin
      if (protect || !in_array(req.addr))
        reply_q <= READ_BLOCKED;
      else
        reply_q <= mem[index_of(req.addr)];
      reply_tgl_q <= ~reply_tgl_q;
    end
  end

  // control/status register and its companions
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      app_mode_q <= CTRL_RESET[CTRL_APP_MODE];
      refused_q <= CTRL_RESET[CTRL_REFUSED];
      addr_q <= 16'h0000;
      data_q <= 8'h00;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == REG_CTRL_STATUS)
        app_mode_q <= reg_wdata_i[CTRL_APP_MODE];
      if (reg_wr_i && reg_addr_i == REG_ADDR_LO)
        addr_q[7:0] <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == REG_ADDR_HI)
        addr_q[15:8] <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == REG_DATA)
        data_q <= reg_wdata_i;
      // a refusal in the clearing cycle survives the clear
      if (refuse)
        refused_q <= 1'b1;
      else if (reg_wr_i && reg_addr_i == REG_CTRL_STATUS && reg_wdata_i[CTRL_REFUSED])
        refused_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_o <= CTRL_RESET;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        REG_CTRL_STATUS:
        begin
          reg_rdata_o <= CTRL_RESET;
          reg_rdata_o[CTRL_APP_MODE] <= app_mode_q;
          reg_rdata_o[CTRL_BUSY] <= state_q != ENG_IDLE;
          reg_rdata_o[CTRL_REFUSED] <= refused_q;
          reg_rdata_o[CTRL_PROTECT] <= protect;
          reg_rdata_o[CTRL_BOARD_MODE] <= board_mode_q;
        end
        REG_ADDR_LO: reg_rdata_o <= addr_q[7:0];
        REG_ADDR_HI: reg_rdata_o <= addr_q[15:8];
        REG_DATA: reg_rdata_o <= in_array(addr_q) ? mem[index_of(addr_q)] : READ_BLOCKED;
        REG_OPTION: reg_rdata_o <= option_q;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
    else
      reg_rdata_o <= 8'h00;
  end

  // the application must leave the link pins alone while a tool is attached
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_pins_reserved_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      link_pins_reserved_o <= pin_q[1] | pin_q[2];
      busy_o <= start_erase || (state_q == ENG_ERASE && erase_ptr_q != erase_end_q);
    end
  end
endmodule

// file: shared/fspc_pkg.sv
// package for the sector program flash controller: register map, link commands, carriers
// assumes one system clock domain plus the in-circuit link clock domain
// Function
// - erase whole array or single sectors; program one byte at a time
// - sector erase or program never changes bytes of other sectors
// - sectors zero and one are 4 Kbytes; sector zero spans F000h-FFFFh
// - 4K array has sector zero, 8K adds one, larger adds two
// - tool and in-circuit modes may program and erase all sectors and options
// - application mode refuses write or erase of sector zero
// - active read-out protection stops any external read of the array
// - removing protection first erases the whole array automatically
// - protection is one bit of the option byte
// - link is serial clock, two-way data, select/voltage pin and reset
// - application keeps off link clock and data while tool is attached
// - 8-bit control/status register at 29h, reset 00h, for tool software
package fspc_pkg;
  localparam logic [7:0] REG_CTRL_STATUS = 8'h29;
  localparam logic [7:0] REG_ADDR_LO = 8'h2A;
  localparam logic [7:0] REG_ADDR_HI = 8'h2B;
  localparam logic [7:0] REG_DATA = 8'h2C;
  localparam logic [7:0] REG_OPTION = 8'h2D;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_APP_MODE = 0;
  localparam int CTRL_PROG = 1;
  localparam int CTRL_SECT_ERASE = 2;
  localparam int CTRL_MASS_ERASE = 3;
  localparam int CTRL_BUSY = 4;
  localparam int CTRL_REFUSED = 5;
  localparam int CTRL_PROTECT = 6;
  localparam int CTRL_BOARD_MODE = 7;
  localparam int OPT_READOUT_PROTECT = 0;
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] READ_BLOCKED = 8'h00;
  localparam logic [15:0] SECTOR0_BASE = 16'hF000;
  localparam logic [15:0] SECTOR1_BASE = 16'hE000;
  localparam logic [15:0] TOP_ADDR = 16'hFFFF;
  localparam int SECTOR_BYTES = 4096;
  localparam int ADDR_SPACE = 65536;
  localparam logic [7:0] CMD_ENTER = 8'h01;
  localparam logic [7:0] CMD_PROG = 8'h02;
  localparam logic [7:0] CMD_SECT_ERASE = 8'h03;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h04;
  localparam logic [7:0] CMD_READ = 8'h05;
  localparam logic [7:0] CMD_OPTION = 8'h06;
  localparam int FRAME_BITS = 32;
  localparam int REPLY_BITS = 8;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_PROG = 3'b001,
    OP_SECT_ERASE = 3'b010,
    OP_MASS_ERASE = 3'b011,
    OP_OPTION = 3'b100,
    OP_READ = 3'b101,
    OP_ENTER = 3'b110
  } fspc_op_t;

  typedef enum logic [0:0] {
    ENG_IDLE = 1'b0,
    ENG_ERASE = 1'b1
  } fspc_eng_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [7:0] data;
  } fspc_frame_t;

  typedef struct packed {
    fspc_op_t op;
    logic [15:0] addr;
    logic [7:0] data;
  } fspc_req_t;
endpackage

// file: verilog/fspc_link.sv
// link-clock side of the in-circuit serial port: frame receiver and reply shifter
// assumes the tool clocks a frame only while the select pin is high, msb first
`timescale 1ns/1ps
module fspc_link
(
  input wire logic link_clk_i,
  input wire logic reset_n_i,
  input wire logic select_i,
  input wire logic data_i,
  input wire logic [7:0] reply_i,
  input wire logic reply_tgl_i,
  output fspc_pkg::fspc_frame_t frame_o,
  output logic frame_tgl_o,
  output logic data_o,
  output logic data_oe_o
);
  import fspc_pkg::*;

  logic [1:0] rst_q;
  logic [2:0] rep_sync_q;
  logic rep_seen_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic [5:0] bit_cnt_q;
  logic [REPLY_BITS-1:0] tx_q;
  logic [3:0] tx_cnt_q;
  logic link_rst_n;

  // link clock may stop; reset asserts at once and releases on link edges
  always_ff @(posedge link_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_q <= 2'b00;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign link_rst_n = rst_q[1];

  always_ff @(posedge link_clk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
      rep_sync_q <= 3'b000;
    else
      rep_sync_q <= {rep_sync_q[1:0], reply_tgl_i};
  end

  // receive: data is sampled on the link's own clock, no crossing needed
  always_ff @(posedge link_clk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      shift_q <= '0;
      bit_cnt_q <= 6'h00;
      frame_o <= '0;
      frame_tgl_o <= 1'b0;
    end
    // select moves with the link clock like data; a one-clock deselect must
    // restart the frame, and a filtered copy would miss a gap that short
    else if (!select_i)
      bit_cnt_q <= 6'h00;
    else if (tx_cnt_q == 4'h0)
    begin
      shift_q <= {shift_q[FRAME_BITS-2:0], data_i};
      if (bit_cnt_q == 6'(FRAME_BITS - 1))
      begin
        // frame stays put until the next one, far longer than the crossing takes
        frame_o <= {shift_q[FRAME_BITS-2:0], data_i};
        frame_tgl_o <= ~frame_tgl_o;
        bit_cnt_q <= 6'h00;
      end
      else
        bit_cnt_q <= bit_cnt_q + 6'h01;
    end
  end

  // reply: drive the data pin for eight link clocks once a reply arrives
  always_ff @(posedge link_clk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      rep_seen_q <= 1'b0;
      tx_q <= '0;
      tx_cnt_q <= 4'h0;
      data_o <= 1'b0;
      data_oe_o <= 1'b0;
    end
    else if (rep_sync_q[1] == rep_sync_q[2] && rep_sync_q[2] != rep_seen_q)
    begin
      rep_seen_q <= rep_sync_q[2];
      tx_q <= {reply_i[REPLY_BITS-2:0], 1'b0};
      tx_cnt_q <= 4'(REPLY_BITS);
      data_o <= reply_i[REPLY_BITS-1];
      data_oe_o <= 1'b1;
    end
    else if (tx_cnt_q != 4'h0)
    begin
      tx_cnt_q <= tx_cnt_q - 4'h1;
      data_o <= tx_q[REPLY_BITS-1];
      tx_q <= {tx_q[REPLY_BITS-2:0], 1'b0};
      data_oe_o <= (tx_cnt_q != 4'h1);
    end
  end
endmodule

// file: testbench/fspc_properties.sv
// port checker for fspc_top
// assumes it is bound onto every fspc_top instance
`timescale 1ns/1ps
module fspc_chk
#(
  parameter int ARRAY_BYTES = 32768
)
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic tool_socket_mode_i,
  input wire logic prog_voltage_select_i,
  input wire logic incircuit_link_data_oe_o,
  input wire logic link_pins_reserved_o,
  input wire logic busy_o
);
  import fspc_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic [16:0] busy_cnt_q;
  logic idle_pins;
  assign idle_pins = !tool_socket_mode_i && !prog_voltage_select_i;
  // length of the last busy run, sampled the cycle busy drops
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      busy_cnt_q <= '0;
    else if (busy_o)
      busy_cnt_q <= busy_cnt_q + 17'h1;
    else
      busy_cnt_q <= '0;
  end
  property p_rdata_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_unmapped;
    $past(reg_rd_i) && ($past(reg_addr_i) < 8'h29 || $past(reg_addr_i) > 8'h2D)
      |-> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_status_busy;
    $past(reg_rd_i) && $past(reg_addr_i) == 8'h29
      |-> reg_rdata_o[4] == $past(busy_o) && !reg_rdata_o[1];
  endproperty
  a_status_busy: assert property (p_status_busy) else $error("status busy bit wrong");
  property p_erase_len;
    $fell(busy_o) |-> busy_cnt_q == ARRAY_BYTES || busy_cnt_q == 4096
      || busy_cnt_q == ARRAY_BYTES - 8192;
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase length wrong");
  property p_tool_erase;
    tool_socket_mode_i [*6] ##1 (reg_wr_i && reg_addr_i == 8'h29
      && reg_wdata_i[3:1] == 3'b100 && !busy_o) |=> busy_o [*8];
  endproperty
  a_tool_erase: assert property (p_tool_erase) else $error("tool mass erase not run");
  property p_app_mass;
    idle_pins [*6] ##1 (reg_wr_i && reg_addr_i == 8'h29 && reg_wdata_i[3:1] == 3'b100
      && !busy_o) |=> !busy_o;
  endproperty
  a_app_mass: assert property (p_app_mass) else $error("app mass erase ran");
  property p_resv_on;
    !idle_pins [*6] |-> link_pins_reserved_o;
  endproperty
  a_resv_on: assert property (p_resv_on) else $error("link pins not reserved");
  property p_resv_off;
    idle_pins [*6] |-> !link_pins_reserved_o;
  endproperty
  a_resv_off: assert property (p_resv_off) else $error("link pins still reserved");
  property p_oe_resv;
    incircuit_link_data_oe_o |-> link_pins_reserved_o;
  endproperty
  a_oe_resv: assert property (p_oe_resv) else $error("data driven without tool");
endmodule

bind fspc_top fspc_chk #(.ARRAY_BYTES(ARRAY_BYTES)) u_chk (
  .clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .tool_socket_mode_i(tool_socket_mode_i),
  .prog_voltage_select_i(prog_voltage_select_i),
  .incircuit_link_data_oe_o(incircuit_link_data_oe_o),
  .link_pins_reserved_o(link_pins_reserved_o),
  .busy_o(busy_o)
);

// file: testbench/fspc_tool_model.sv
// in-circuit programming tool: sends frames, collects reply bytes
// assumes the bench resolves the shared data wire from the device enable alone
`timescale 1ns/1ps
module fspc_tool_model
(
  output logic link_clk_o,
  output logic select_o,
  output logic data_o,
  input wire logic data_i,
  input wire logic dev_oe_i
);
  initial
  begin
    link_clk_o = 1'b0;
    select_o = 1'b0;
    data_o = 1'b1;
  end
  task automatic tick();
    #32 link_clk_o = 1'b1;
    #32 link_clk_o = 1'b0;
  endtask
  task automatic send(input logic [31:0] f);
    // one deselected clock restarts the frame but is too short to end in-circuit mode;
    // from idle a second clock lets the link side leave reset first
    if (!select_o)
      tick();
    select_o = 1'b0;
    tick();
    select_o = 1'b1;
    for (int i = 31; i >= 0; i--)
    begin
      data_o = f[i];
      tick();
    end
    // clock then stands still; no stale bit left on the line
    data_o = ~f[0];
    #2000;
  endtask
  task automatic fetch(output logic [7:0] b);
    // a missing reply leaves unknowns, which the compare rejects
    b = 'x;
    repeat (20)
    begin
      tick();
      data_o = ~data_o;
      if (dev_oe_i === 1'b1)
        b = {b[6:0], data_i};
    end
  endtask
endmodule

// file: testbench/tb.sv
// self-checking bench for fspc_top with an 8 Kbyte array
// assumes the tool model drives the link and the bench the register port
`timescale 1ns/1ps
module tb;
  import fspc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] ra = 8'h00;
  logic [7:0] rw = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tool = 1'b0;
  logic [7:0] rdat;
  logic lk_clk, lk_sel, lk_td, lk_dd, lk_oe, busy, resv;
  wire lk_wire = (lk_oe === 1'b1) ? lk_dd : lk_td;
  int failures = 0;
  int comparisons = 0;
  always #50 clk_sys = ~clk_sys;
  fspc_top #(.ARRAY_BYTES(8192)) dut (
    .clk_sys_i(clk_sys), .reset_n_i(rst_n), .reg_addr_i(ra), .reg_wdata_i(rw),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .tool_socket_mode_i(tool),
    .prog_voltage_select_i(lk_sel), .incircuit_link_clock_i(lk_clk),
    .incircuit_link_data_i(lk_wire), .incircuit_link_data_o(lk_dd),
    .incircuit_link_data_oe_o(lk_oe), .link_pins_reserved_o(resv), .busy_o(busy));
  fspc_tool_model tool_m (.link_clk_o(lk_clk), .select_o(lk_sel), .data_o(lk_td),
    .data_i(lk_wire), .dev_oe_i(lk_oe));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    ra <= a;
    rw <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), rdat, e);
    @(posedge clk_sys);
  endtask
  task automatic at(input logic [15:0] a);
    wr8(8'h2A, a[7:0]);
    wr8(8'h2B, a[15:8]);
  endtask
  task automatic op(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
    at(a);
    wr8(8'h2C, d);
    wr8(8'h29, c);
  endtask
  task automatic peek(input logic [15:0] a, input logic [7:0] e);
    at(a);
    rc(8'h2C, e);
  endtask
  task automatic settle();
    int n;
    n = 0;
    repeat (8) @(posedge clk_sys);
    while (busy === 1'b1 && n < 20000)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk("busy", {7'h00, busy}, 8'h00);
  endtask
  task automatic lk(input logic [31:0] f);
    tool_m.send(f);
    @(posedge clk_sys);
  endtask
  task automatic t_reset();
    rc(8'h29, 8'h00);
    rc(8'h2D, 8'h00);
    rc(8'h30, 8'h00);
    chk("reserved", {7'h00, resv}, 8'h00);
  endtask
  task automatic t_tool();
    tool <= 1'b1;
    repeat (6) @(posedge clk_sys);
    wr8(8'h29, 8'h08);
    settle();
    rc(8'h29, 8'h00);
    peek(16'hE000, 8'hFF);
    op(16'hF005, 8'h77, 8'h02);
    peek(16'hF005, 8'h77);
    op(16'hE123, 8'h5A, 8'h02);
    op(16'hE123, 8'h0F, 8'h02);
    peek(16'hE123, 8'h0A);
    chk("reserved", {7'h00, resv}, 8'h01);
    tool <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic t_app();
    logic [7:0] bad [3];
    bad = '{8'h03, 8'h05, 8'h09};
    // app mode on first, so the sector zero and mass erase guards are what refuse
    wr8(8'h29, 8'h01);
    foreach (bad[i])
    begin
      op(16'hF005, 8'h00, bad[i]);
      rc(8'h29, 8'h21);
      wr8(8'h29, 8'h21);
      rc(8'h29, 8'h01);
    end
    peek(16'hF005, 8'h77);
    at(16'hD000);
    wr8(8'h29, 8'h05);
    rc(8'h29, 8'h21);
    wr8(8'h29, 8'h21);
    op(16'hE001, 8'h33, 8'h03);
    peek(16'hE001, 8'h33);
    peek(16'hE123, 8'h0A);
    at(16'hE000);
    wr8(8'h29, 8'h05);
    rc(8'h29, 8'h11);
    settle();
    peek(16'hE123, 8'hFF);
    peek(16'hF005, 8'h77);
    wr8(8'h29, 8'h00);
  endtask
  task automatic t_link();
    logic [7:0] b;
    lk(32'h05F00500);
    rc(8'h29, 8'h20);
    wr8(8'h29, 8'h20);
    lk(32'h01000000);
    rc(8'h29, 8'h80);
    lk(32'h05F00500);
    tool_m.fetch(b);
    @(posedge clk_sys);
    chk("reply", b, 8'h77);
    lk(32'h06000001);
    rc(8'h2D, 8'h01);
    rc(8'h29, 8'hC0);
    lk(32'h05F00500);
    tool_m.fetch(b);
    @(posedge clk_sys);
    chk("reply", b, 8'h00);
    lk(32'h06000000);
    chk("busy", {7'h00, busy}, 8'h01);
    settle();
    rc(8'h2D, 8'h00);
    peek(16'hF005, 8'hFF);
    lk(32'h02F00542);
    peek(16'hF005, 8'h42);
    lk(32'h03F00000);
    settle();
    peek(16'hF005, 8'hFF);
  endtask
  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #5000000;
    failures++;
    complete_run();
  end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_tool();
    t_app();
    t_link();
    complete_run();
  end
endmodule
